// [include/dsh_regs.vh]
// Operation
// - two channels share one PCI master, two functions
// - each channel keeps own configuration and registers
// - wide channel uses line B, narrow line C
// - parity carried throughout; parity and system errors
// - I/O read and write as target and master
// - memory read and write as target and master
// - configuration commands as target only
// - memory read multiple as target and master
// - read line claimed as plain memory read
// - write invalidate claimed as plain memory write
// - never claim or issue unsupported command codes
// - command register bit picks read line or multiple
// - extended commands imply cache line size data
// - burst transfers staged through on-chip buffers
// - 8 or 16 bit, Fast-10 or Fast-20 timing
// - odd parity per SCSI data byte lane
// - same control signals for both widths
// - low data byte IDs win arbitration first
// - differential, activity and terminator power outputs
// - power-down disables all input receivers
`ifndef DSH_REGS_VH
`define DSH_REGS_VH
`define DSH_CMD_IACK     4'h0
`define DSH_CMD_SPECIAL  4'h1
`define DSH_CMD_IORD     4'h2
`define DSH_CMD_IOWR     4'h3
`define DSH_CMD_MEMRD    4'h6
`define DSH_CMD_MEMWR    4'h7
`define DSH_CMD_CFGRD    4'ha
`define DSH_CMD_CFGWR    4'hb
`define DSH_CMD_MRMULT   4'hc
`define DSH_CMD_DAC      4'hd
`define DSH_CMD_MRLINE   4'he
`define DSH_CMD_MWINV    4'hf
`define DSH_KIND_NONE    3'h0
`define DSH_KIND_IO      3'h1
`define DSH_KIND_MEM     3'h2
`define DSH_KIND_CFG     3'h3
`define DSH_REQ_IO       2'h0
`define DSH_REQ_MEM      2'h1
`define DSH_FAST10_DIV   8'd20
`define DSH_FAST20_DIV   8'd10
`endif

// [hw/dsh_scsi_lane.v]
`timescale 1ns/100ps
`include "dsh_regs.vh"
module dsh_scsi_lane
(
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // control
  input  wire       powerDown,
  input  wire       driveEn,
  // transmit byte
  input  wire [7:0] txByte,
  // scsi pins, one byte lane
  input  wire [7:0] pinDataIn,
  input  wire       pinParIn,
  output reg  [7:0] pinDataOut,
  output reg        pinParOut,
  output wire       pinOe,
  // received byte
  output wire [7:0] rxByte,
  output reg        rxParErr
);
  reg [8:0] syncA_q;
  reg [8:0] syncB_q;
  wire [8:0] gated = powerDown ? 9'h000 : {pinParIn, pinDataIn};
  assign pinOe  = driveEn & ~powerDown;
  assign rxByte = syncB_q[7:0];
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_q    <= 9'h000;
      syncB_q    <= 9'h000;
      pinDataOut <= 8'h00;
      pinParOut  <= 1'b1;
      rxParErr   <= 1'b0;
    end
    else
    begin
      syncA_q    <= gated;
      syncB_q    <= syncA_q;
      pinDataOut <= txByte;
      pinParOut  <= ~(^txByte);
      rxParErr   <= ~powerDown & ~driveEn & ~(^syncB_q);
    end
  end
endmodule // dsh_scsi_lane

// [hw/dsh_host_adapter.v]
`timescale 1ns/100ps
`include "dsh_regs.vh"
module dsh_host_adapter
#(
  parameter CLW = 8,
  parameter BUFDEPTH = 16
)
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // pci target decode
  input  wire        tgtFrameStart,
  input  wire [3:0]  tgtCmd,
  input  wire        tgtFunc,
  input  wire        tgtIdsel,
  input  wire        tgtHit,
  input  wire [31:0] pciAd,
  input  wire        pciPar,
  input  wire        pciDataValid,
  output reg         devSelect,
  output reg  [2:0]  tgtKind,
  output reg         tgtFuncOut,
  // pci master issue
  input  wire        mstReq,
  input  wire        mstFunc,
  input  wire [1:0]  mstReqType,
  input  wire        mstWrite,
  input  wire [7:0]  mstLen,
  output reg  [3:0]  mstCmd,
  output reg         mstCmdValid,
  output reg  [7:0]  mstBurstLen,
  // error signals
  output reg         parityErr,
  output reg         systemErr,
  // interrupts
  input  wire        wideIrqReq,
  input  wire        narrowIrqReq,
  output wire        wide_channel_irq_line_n,
  output wire        narrow_channel_irq_line_n,
  // per-channel configuration, function 0 wide, 1 narrow
  input  wire [1:0]  cfgReadMultiple,
  input  wire [1:0]  cfgWide,
  input  wire [1:0]  cfgFast20,
  input  wire [1:0]  cfgTermPowerDown,
  input  wire [1:0]  cfgDiffEnable,
  input  wire [7:0]  cfgCacheLine0,
  input  wire [7:0]  cfgCacheLine1,
  input  wire        powerDown,
  // scsi wide channel
  input  wire [15:0] wideDataIn,
  input  wire [1:0]  wideParIn,
  output wire [15:0] wideDataOut,
  output wire [1:0]  wideParOut,
  output wire [1:0]  wideDataOe,
  output wire [15:0] wideArbIdOut,
  input  wire [15:0] wideTxWord,
  input  wire        wideDrive,
  input  wire [3:0]  wideOwnId,
  input  wire        wideArbitrate,
  output reg         wideArbWon,
  // scsi narrow channel
  input  wire [7:0]  narrowDataIn,
  input  wire        narrowParIn,
  output wire [7:0]  narrowDataOut,
  output wire        narrowParOut,
  output wire        narrowDataOe,
  input  wire [7:0]  narrowTxByte,
  input  wire        narrowDrive,
  // received data
  output wire [15:0] wideRxWord,
  output wire [7:0]  narrowRxByte,
  output wire [2:0]  scsiParErr,
  // per-channel side outputs
  output reg  [1:0]  diffSense,
  output reg  [1:0]  activityLed,
  output reg  [1:0]  termPowerDown,
  output reg  [1:0]  xferTick,
  output reg  [1:0]  busWide,
  // burst staging buffer
  input  wire        bufWrite,
  input  wire [31:0] bufWData,
  input  wire        bufRead,
  output reg  [31:0] bufRData,
  output wire        bufFull,
  output wire        bufEmpty
);
  // ******************************
  // target command decode
  // ******************************
  reg [2:0] kind_d;
  always @*
  begin
    case (tgtCmd)
      `DSH_CMD_IORD, `DSH_CMD_IOWR:
        kind_d = `DSH_KIND_IO;
      `DSH_CMD_MEMRD, `DSH_CMD_MRMULT, `DSH_CMD_MRLINE:
        kind_d = `DSH_KIND_MEM;
      `DSH_CMD_MEMWR, `DSH_CMD_MWINV:
        kind_d = `DSH_KIND_MEM;
      `DSH_CMD_CFGRD, `DSH_CMD_CFGWR:
        kind_d = tgtIdsel ? `DSH_KIND_CFG : `DSH_KIND_NONE;
      default:
        kind_d = `DSH_KIND_NONE;
    endcase
  end
  // read line and multiple both land as plain reads downstream
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      devSelect  <= 1'b0;
      tgtKind    <= `DSH_KIND_NONE;
      tgtFuncOut <= 1'b0;
    end
    else
    begin
      devSelect  <= tgtFrameStart & (kind_d != `DSH_KIND_NONE)
                    & (tgtHit | kind_d == `DSH_KIND_CFG);
      tgtKind    <= tgtFrameStart ? kind_d : `DSH_KIND_NONE;
      tgtFuncOut <= tgtFunc;
    end
  end

  // ******************************
  // master command selection
  // ******************************
  wire       useMult  = cfgReadMultiple[mstFunc];
  wire [7:0] lineSize = mstFunc ? cfgCacheLine1 : cfgCacheLine0;
  wire       longXfer = (lineSize != 8'h00) && (mstLen >= lineSize);
  reg  [3:0] mcmd_d;
  always @*
  begin
    case (mstReqType)
      `DSH_REQ_IO:
        mcmd_d = mstWrite ? `DSH_CMD_IOWR : `DSH_CMD_IORD;
      `DSH_REQ_MEM:
        if (mstWrite)
          mcmd_d = longXfer ? `DSH_CMD_MWINV : `DSH_CMD_MEMWR;
        else if (longXfer)
          mcmd_d = useMult ? `DSH_CMD_MRMULT : `DSH_CMD_MRLINE;
        else
          mcmd_d = `DSH_CMD_MEMRD;
      default:
        mcmd_d = `DSH_CMD_MEMRD;
    endcase
  end
  // one shared master, the two functions time-share it
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mstCmd      <= `DSH_CMD_MEMRD;
      mstCmdValid <= 1'b0;
      mstBurstLen <= 8'h00;
    end
    else
    begin
      mstCmdValid <= mstReq;
      if (mstReq)
      begin
        mstCmd      <= mcmd_d;
        // whole cache lines at least for extended commands
        mstBurstLen <= (longXfer && mcmd_d != `DSH_CMD_MEMRD
                        && mcmd_d != `DSH_CMD_MEMWR) ? ((mstLen < lineSize) ?
                        lineSize : mstLen) : mstLen;
      end
    end
  end

  // ******************************
  // pci parity and errors
  // ******************************
  reg [31:0] parHold_q;
  reg        parPend_q;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      parHold_q <= 32'h00000000;
      parPend_q <= 1'b0;
      parityErr <= 1'b0;
      systemErr <= 1'b0;
    end
    else
    begin
      // parity lands one clock after its data
      // only data phases that were claimed get judged
      parPend_q <= pciDataValid & devSelect;
      if (pciDataValid)
        parHold_q <= pciAd;
      parityErr <= parPend_q & (^{pciPar, parHold_q});
      systemErr <= tgtFrameStart & (^{pciPar, pciAd});
    end
  end

  // ******************************
  // interrupt lines
  // ******************************
  assign wide_channel_irq_line_n   = ~wideIrqReq;
  assign narrow_channel_irq_line_n = ~narrowIrqReq;

  // ******************************
  // scsi byte lanes
  // ******************************
  wire [2:0] laneErr;
  wire       narrowOnWide = ~cfgWide[0];
  dsh_scsi_lane uLaneWideLo
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .powerDown  (powerDown),
    .driveEn    (wideDrive),
    .txByte     (wideTxWord[7:0]),
    .pinDataIn  (wideDataIn[7:0]),
    .pinParIn   (wideParIn[0]),
    .pinDataOut (wideDataOut[7:0]),
    .pinParOut  (wideParOut[0]),
    .pinOe      (wideDataOe[0]),
    .rxByte     (wideRxWord[7:0]),
    .rxParErr   (laneErr[0])
  );
  // high lane idles undriven in 8-bit mode
  dsh_scsi_lane uLaneWideHi
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .powerDown  (powerDown),
    .driveEn    (wideDrive & ~narrowOnWide),
    .txByte     (wideTxWord[15:8]),
    .pinDataIn  (wideDataIn[15:8]),
    .pinParIn   (wideParIn[1]),
    .pinDataOut (wideDataOut[15:8]),
    .pinParOut  (wideParOut[1]),
    .pinOe      (wideDataOe[1]),
    .rxByte     (wideRxWord[15:8]),
    .rxParErr   (laneErr[1])
  );
  dsh_scsi_lane uLaneNarrow
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .powerDown  (powerDown),
    .driveEn    (narrowDrive),
    .txByte     (narrowTxByte),
    .pinDataIn  (narrowDataIn),
    .pinParIn   (narrowParIn),
    .pinDataOut (narrowDataOut),
    .pinParOut  (narrowParOut),
    .pinOe      (narrowDataOe),
    .rxByte     (narrowRxByte),
    .rxParErr   (laneErr[2])
  );
  // unused high lane parity is ignored in 8-bit mode
  assign scsiParErr = {laneErr[2], laneErr[1] & ~narrowOnWide, laneErr[0]};

  // ******************************
  // wide arbitration
  // ******************************
  // ids on the low byte beat any id on the high byte
  wire [15:0] arbBus = wideRxWord;
  reg         higherSeen;
  integer     i;
  always @*
  begin
    higherSeen = 1'b0;
    for (i = 0; i < 16; i = i + 1)
    begin
      if (arbBus[i] && i[3:0] != wideOwnId)
      begin
        if (wideOwnId[3] ? (i < 8 || i > wideOwnId)
                         : (i < 8 && i > wideOwnId))
          higherSeen = 1'b1;
      end
    end
  end
  assign wideArbIdOut = wideArbitrate ? (16'h0001 << wideOwnId) : 16'h0000;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wideArbWon <= 1'b0;
    else
      wideArbWon <= wideArbitrate & ~higherSeen & ~powerDown;
  end

  // ******************************
  // channel timing and side outputs
  // ******************************
  reg [7:0] divCnt0_q;
  reg [7:0] divCnt1_q;
  wire [7:0] divTop0 = cfgFast20[0] ? `DSH_FAST20_DIV : `DSH_FAST10_DIV;
  wire [7:0] divTop1 = cfgFast20[1] ? `DSH_FAST20_DIV : `DSH_FAST10_DIV;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      divCnt0_q     <= 8'h00;
      divCnt1_q     <= 8'h00;
      xferTick      <= 2'b00;
      busWide       <= 2'b00;
      diffSense     <= 2'b00;
      activityLed   <= 2'b00;
      termPowerDown <= 2'b00;
    end
    else
    begin
      divCnt0_q <= (divCnt0_q >= divTop0 - 8'h01) ? 8'h00 : divCnt0_q + 8'h01;
      divCnt1_q <= (divCnt1_q >= divTop1 - 8'h01) ? 8'h00 : divCnt1_q + 8'h01;
      xferTick  <= {divCnt1_q == 8'h00, divCnt0_q == 8'h00};
      busWide   <= {1'b0, cfgWide[0]};
      diffSense <= cfgDiffEnable & {2{~powerDown}};
      activityLed   <= {narrowDrive, wideDrive | wideArbitrate};
      termPowerDown <= cfgTermPowerDown;
    end
  end

  // ******************************
  // burst staging buffer
  // ******************************
  localparam AW = $clog2(BUFDEPTH);
  reg [31:0] mem [0:BUFDEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  assign bufEmpty = (wp_q == rp_q);
  assign bufFull  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  always @(posedge sys_clk)
  begin
    if (bufWrite && !bufFull)
      mem[wp_q[AW-1:0]] <= bufWData;
  end
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q     <= {(AW+1){1'b0}};
      rp_q     <= {(AW+1){1'b0}};
      bufRData <= 32'h00000000;
    end
    else
    begin
      if (bufWrite && !bufFull)
        wp_q <= wp_q + 1'b1;
      if (bufRead && !bufEmpty)
      begin
        bufRData <= mem[rp_q[AW-1:0]];
        rp_q     <= rp_q + 1'b1;
      end
    end
  end
endmodule // dsh_host_adapter

// [sim/dsh_chk.sv]
`timescale 1ns/100ps
module dsh_chk
(
  // clock and reset
  input wire        sys_clk,
  input wire        rst,
  // target and master
  input wire        tgtFrameStart,
  input wire [3:0]  tgtCmd,
  input wire        tgtIdsel,
  input wire        tgtHit,
  input wire        devSelect,
  input wire        mstReq,
  input wire        mstCmdValid,
  input wire [3:0]  mstCmd,
  // interrupts
  input wire        wideIrqReq,
  input wire        narrowIrqReq,
  input wire        wide_channel_irq_line_n,
  input wire        narrow_channel_irq_line_n,
  // scsi
  input wire [15:0] wideDataOut,
  input wire [1:0]  wideParOut,
  input wire [7:0]  narrowDataOut,
  input wire        narrowParOut,
  input wire        powerDown,
  input wire [15:0] wideRxWord
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****
  // decode
  // ****
  sequence sMemIo;
    tgtFrameStart && tgtHit && (tgtCmd inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf});
  endsequence
  sequence sCfg;
    tgtFrameStart && tgtIdsel && (tgtCmd[3:1] == 3'h5);
  endsequence
  sequence sOther;
    tgtFrameStart && (tgtCmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd});
  endsequence
  AST_CLAIM_MEMIO: assert property (sMemIo |=> devSelect)
    else $error("memory or io command not claimed");
  AST_CLAIM_CFG: assert property (sCfg |=> devSelect)
    else $error("configuration command not claimed");
  AST_NO_CLAIM: assert property (sOther |=> !devSelect)
    else $error("unsupported command claimed");
  AST_CFG_IDSEL: assert property (
    tgtFrameStart && !tgtIdsel && (tgtCmd[3:1] == 3'h5) |=> !devSelect)
    else $error("configuration claimed without idsel");
  AST_MST_CMD: assert property (mstReq |=> mstCmdValid &&
    !(mstCmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd}))
    else $error("master answer missing or illegal");
  AST_IRQ_LINES: assert property (
    (wide_channel_irq_line_n == !wideIrqReq) && (narrow_channel_irq_line_n == !narrowIrqReq))
    else $error("interrupt line mismatch");
  AST_PAR_ODD: assert property (
    (^{wideDataOut[7:0], wideParOut[0]}) && (^{wideDataOut[15:8], wideParOut[1]})
    && (^{narrowDataOut, narrowParOut}))
    else $error("scsi parity not odd");
  AST_PD_RX: assert property (powerDown [*4] |-> wideRxWord == 16'h0)
    else $error("receivers live in power down");
endmodule // dsh_chk

// [sim/dsh_scsi_peer.sv]
`timescale 1ns/100ps
module dsh_scsi_peer
(
  // design side
  input  wire [15:0] pinOut,
  input  wire [1:0]  pinParOut,
  input  wire [1:0]  pinOe,
  // target control
  input  wire [15:0] peerWord,
  input  wire        badPar,
  // wire levels
  output wire [15:0] busData,
  output wire [1:0]  busPar
);
  // ****
  // target
  // ****
  // board never cuts terminator power
  wire        termPower = 1'b1;
  // without terminator power the lines would sag low
  wire [15:0] peerLvl   = termPower ? peerWord : 16'h0000;
  // bad parity only on the low lane, so lanes are told apart
  wire [1:0]  peerPar   = {~^peerLvl[15:8], (~^peerLvl[7:0]) ^ badPar};
  // peer ids sit on the data lines during arbitration
  assign busData = {pinOe[1] ? pinOut[15:8] : peerLvl[15:8],
                    pinOe[0] ? pinOut[7:0] : peerLvl[7:0]};
  assign busPar = {pinOe[1] ? pinParOut[1] : peerPar[1], pinOe[0] ? pinParOut[0] : peerPar[0]};
endmodule // dsh_scsi_peer

// [sim/dsh_host_adapter_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin failCount++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module dsh_host_adapter_bench;
  logic sys_clk = 0, rst = 1;
  logic tgtFrameStart, tgtIdsel, tgtHit, tgtFunc, pciPar, pciDataValid, mstReq, mstFunc;
  logic mstWrite, wideIrqReq, narrowIrqReq, powerDown, wideDrive, wideArbitrate;
  logic narrowDrive, bufWrite, bufRead, badPar;
  logic [3:0] tgtCmd, wideOwnId;
  logic [1:0] mstReqType, cfgReadMultiple, cfgWide, cfgFast20, cfgTermPowerDown, cfgDiffEnable;
  logic [7:0] mstLen, cfgCacheLine0, cfgCacheLine1, narrowTxByte;
  logic [15:0] wideTxWord, peerWord;
  logic [31:0] pciAd, bufWData;
  wire devSelect, tgtFuncOut, mstCmdValid, parityErr, systemErr, wideArbWon, narrowParOut;
  wire wide_channel_irq_line_n, narrow_channel_irq_line_n, narrowDataOe, bufFull, bufEmpty;
  wire narrowParIn;
  wire [2:0] tgtKind, scsiParErr;
  wire [3:0] mstCmd;
  wire [7:0] mstBurstLen, narrowDataOut, narrowRxByte, narrowDataIn;
  wire [15:0] wideDataOut, wideArbIdOut, wideRxWord, wideDataIn;
  wire [1:0] wideParOut, wideDataOe, wideParIn, diffSense, activityLed, termPowerDown;
  wire [1:0] xferTick, busWide;
  wire [31:0] bufRData;
  int failCount = 0, samplesChecked = 0;
  always #2.5 sys_clk = ~sys_clk;
  dsh_host_adapter i_dsh_host_adapter (.*);
  dsh_scsi_peer i_dsh_scsi_peer (.pinOut(wideDataOut), .pinParOut(wideParOut),
    .pinOe(wideDataOe), .peerWord(peerWord), .badPar(badPar), .busData(wideDataIn),
    .busPar(wideParIn));
  assign narrowDataIn = narrowDataOe ? narrowDataOut : 8'h5a;
  assign narrowParIn = narrowDataOe ? narrowParOut : 1'b1;
  // ****
  // scenarios
  // ****
  task tgtOne(input [3:0] c, input h, input s, input e, input [2:0] k);
    @(negedge sys_clk);
    {tgtFrameStart, tgtCmd, tgtHit, tgtIdsel, tgtFunc} = {1'b1, c, h, s, c[0]};
    @(negedge sys_clk);
    tgtFrameStart = 0;
    `CHK(devSelect, e)
    if (e) `CHK({tgtKind, tgtFuncOut}, {k, c[0]})
  endtask
  task tgtTest;
    logic [15:0] sup;
    logic cf;
    sup = 16'hdccc;
    for (int i = 0; i < 16; i++)
    begin
      cf = (i[3:1] == 3'h5);
      tgtOne(i[3:0], !cf, cf, sup[i], (i[3:1] == 3'h1) ? 3'h1 : cf ? 3'h3 : 3'h2);
    end
    tgtOne(4'ha, 1, 0, 0, 0);
    tgtOne(4'h6, 0, 0, 0, 0);
  endtask
  task mstOne(input f, input [1:0] t, input w, input [7:0] n, input [3:0] e);
    @(negedge sys_clk);
    {mstReq, mstFunc, mstReqType, mstWrite, mstLen} = {1'b1, f, t, w, n};
    @(negedge sys_clk);
    mstReq = 0;
    `CHK({mstCmdValid, mstCmd, mstBurstLen}, {1'b1, e, n})
  endtask
  task mstTest;
    {cfgCacheLine0, cfgCacheLine1, cfgReadMultiple} = {8'h08, 8'h04, 2'b10};
    mstOne(0, 0, 0, 8'h01, 4'h2);
    mstOne(0, 0, 1, 8'h01, 4'h3);
    mstOne(0, 1, 0, 8'h07, 4'h6);
    mstOne(0, 1, 0, 8'h08, 4'he);
    mstOne(1, 1, 0, 8'h04, 4'hc);
    mstOne(1, 1, 0, 8'h03, 4'h6);
    mstOne(0, 1, 1, 8'h08, 4'hf);
    mstOne(0, 1, 1, 8'h07, 4'h7);
    cfgCacheLine0 = 0;
    mstOne(0, 1, 0, 8'hff, 4'h6);
    mstOne(1, 2, 1, 8'h10, 4'h6);
  endtask
  task irqTest;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge sys_clk);
      {wideIrqReq, narrowIrqReq} = i[1:0];
      #1 `CHK({wide_channel_irq_line_n, narrow_channel_irq_line_n}, ~i[1:0])
    end
  endtask
  task sideTest;
    @(negedge sys_clk);
    {cfgWide, cfgTermPowerDown, cfgDiffEnable} = {2'h3, 2'h2, 2'h1};
    {narrowDrive, wideArbitrate, wideOwnId} = {1'b1, 1'b1, 4'h5};
    repeat (3) @(negedge sys_clk);
    `CHK({busWide, termPowerDown}, {2'b01, 2'b10})
    `CHK({diffSense, activityLed}, {2'h1, 2'h3})
    `CHK(wideArbIdOut, 16'h0020)
    {narrowDrive, wideArbitrate} = 2'h0;
  endtask
  task scsiTest;
    peerWord = 16'h1234;
    repeat (4) @(negedge sys_clk);
    `CHK({wideRxWord, narrowRxByte, scsiParErr}, {16'h1234, 8'h5a, 3'h0})
    badPar = 1;
    repeat (4) @(negedge sys_clk);
    `CHK(scsiParErr, 3'b001)
    {badPar, wideDrive, wideTxWord} = {1'b0, 1'b1, 16'hc3a5};
    repeat (2) @(negedge sys_clk);
    `CHK({wideDataOe, wideDataOut}, {2'b11, 16'hc3a5})
    {wideDrive, powerDown} = 2'b01;
    repeat (5) @(negedge sys_clk);
    `CHK(wideRxWord, 16'h0)
    powerDown = 0;
  endtask
  task arbOne(input [3:0] id, input [15:0] w, input e);
    {peerWord, wideOwnId} = {w, id};
    repeat (4) @(negedge sys_clk);
    wideArbitrate = 1;
    repeat (2) @(negedge sys_clk);
    `CHK(wideArbWon, e)
    wideArbitrate = 0;
    @(negedge sys_clk);
  endtask
  task tickTest;
    logic [7:0] n0, n1;
    {cfgFast20, n0, n1} = {2'h1, 16'h0000};
    repeat (20) @(negedge sys_clk);
    repeat (40)
    begin
      @(negedge sys_clk);
      n0 = n0 + xferTick[0];
      n1 = n1 + xferTick[1];
    end
    `CHK({n0, n1}, {8'h04, 8'h02})
  endtask
  task bufTest;
    `CHK({bufFull, bufEmpty}, 2'h1)
    for (int i = 0; i < 17; i++)
    begin
      @(negedge sys_clk);
      {bufWrite, bufWData} = {1'b1, 32'h0000a000 + i};
    end
    @(negedge sys_clk);
    bufWrite = 0;
    `CHK({bufFull, bufEmpty}, 2'h2)
    for (int i = 0; i < 16; i++)
    begin
      bufRead = 1;
      @(negedge sys_clk);
      `CHK(bufRData, 32'h0000a000 + i)
    end
    bufRead = 0;
    @(negedge sys_clk);
    `CHK({bufFull, bufEmpty}, 2'h1)
  endtask
  task parOne(input b);
    @(negedge sys_clk);
    {tgtFrameStart, tgtCmd, tgtHit, pciAd, pciPar} = {1'b1, 4'h7, 1'b1, 32'h00000001, ~b};
    @(negedge sys_clk);
    {tgtFrameStart, pciDataValid, pciAd} = {1'b0, 1'b1, 32'h00000003};
    `CHK({devSelect, systemErr}, {1'b1, b})
    @(negedge sys_clk);
    {pciDataValid, pciPar} = {1'b0, b};
    @(negedge sys_clk);
    `CHK({parityErr, systemErr}, {b, 1'b0})
    {tgtHit, pciAd, pciPar} = '0;
  endtask
  task wrapUp;
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {tgtFrameStart, tgtIdsel, tgtHit, tgtFunc, pciPar, pciDataValid, mstReq, mstFunc} = '0;
    {mstWrite, wideIrqReq, narrowIrqReq, powerDown, wideDrive, wideArbitrate} = '0;
    {narrowDrive, bufWrite, bufRead, badPar, tgtCmd, wideOwnId, mstReqType} = '0;
    {cfgReadMultiple, cfgWide, cfgFast20, cfgTermPowerDown, cfgDiffEnable} = '0;
    {mstLen, cfgCacheLine0, cfgCacheLine1, narrowTxByte, wideTxWord, peerWord} = '0;
    {pciAd, bufWData} = '0;
    repeat (3) @(negedge sys_clk);
    rst = 0;
    tgtTest;
    mstTest;
    irqTest;
    sideTest;
    scsiTest;
    arbOne(4'h3, 16'h0200, 1);
    arbOne(4'h9, 16'h0008, 0);
    arbOne(4'h5, 16'h0004, 1);
    arbOne(4'h2, 16'h0020, 0);
    tickTest;
    bufTest;
    parOne(0);
    parOne(1);
    wrapUp;
  end
  // whole run is well under a thousand cycles
  initial
  begin
    #20000;
    failCount++;
    wrapUp;
  end
endmodule // dsh_host_adapter_bench
bind dsh_host_adapter dsh_chk i_dsh_chk (.*);
